// file: cmpctl_pkg.sv
package cmpctl_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_CMP_CTL   = 8'h50;
   localparam logic [7:0] IDX_CONV_B    = 8'h7B;
   localparam logic [7:0] IDX_CONV_CHAN = 8'h7C;
   localparam logic [7:0] IDX_PIN_BUF   = 8'h7D;
   localparam logic [7:0] IDX_IRQ_STAT  = 8'h7E;
   localparam logic [7:0] IDX_IRQ_MASK  = 8'h7F;
   localparam int         ADDR_W        = 12;
   // comparator control/status fields
   localparam int BIT_OFF      = 7;
   localparam int BIT_REFSEL   = 6;
   localparam int BIT_RESULT   = 5;
   localparam int BIT_FLAG     = 4;
   localparam int BIT_IE       = 3;
   localparam int BIT_ROUTE    = 2;
   localparam int BIT_MODE_HI  = 1;
   localparam int BIT_MODE_LO  = 0;
   // converter control b fields
   localparam int BIT_NEG_MUX  = 6;
   localparam int TRIG_HI      = 2;
   // converter channel register fields (enable and channel)
   localparam int BIT_CONV_EN  = 7;
   localparam int CHAN_HI      = 2;
   // pin buffer disable fields
   localparam int BIT_NEG_BUF  = 1;
   localparam int BIT_POS_BUF  = 0;
   // interrupt status / mask layout
   localparam int IRQ_BITS     = 2;
   localparam int BIT_IRQ_EVT  = 0;
   localparam int BIT_IRQ_CHG  = 1;
   // reset values
   localparam logic [7:0] RST_CMP_CTL   = 8'h00;
   localparam logic [7:0] RST_CONV_B    = 8'h00;
   localparam logic [7:0] RST_CONV_CHAN = 8'h00;
   localparam logic [7:0] RST_PIN_BUF   = 8'h00;
   localparam logic [IRQ_BITS-1:0] RST_IRQ = 2'h0;
   // interrupt mode select encodings
   localparam logic [1:0] MODE_TOGGLE  = 2'h0;
   localparam logic [1:0] MODE_RSVD    = 2'h1;
   localparam logic [1:0] MODE_FALL    = 2'h2;
   localparam logic [1:0] MODE_RISE    = 2'h3;
   // synchroniser depth in system clocks
   localparam int SYNC_STAGES  = 2;
endpackage

// file: cmpctl_top.sv
// Overview of operation
// - result high when positive exceeds negative
// - mux on, converter off: channel N negative
// - otherwise dedicated negative pin is used
// - comparator-off bit removes comparator power
// - reference select feeds bandgap to positive
// - result synchronised, two cycles
// - event flag set on selected edge
// - vector execution clears event flag
// - writing one clears flag, zero keeps
// - request needs enable and global bit
// - mode: toggle, reserved, falling, rising
// - capture route feeds timer capture input
// - route off: capture path disconnected
// - buffer-off bit disables buffer, reads zero
// - buffer register upper six bits read zero
`timescale 1ns/100ps
`default_nettype none
module cmpctl_top
   import cmpctl_pkg::*;
#(
   parameter int LVL_W = 10
) (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // apb slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [cmpctl_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]          pwdata,
   output logic                      pready,
   output logic [31:0]               prdata,
   output logic                      pslverr,
   // analog levels, sampled as numbers
   input  wire logic [LVL_W-1:0]     positive_input_pin,
   input  wire logic [LVL_W-1:0]     negative_input_pin,
   input  wire logic [8*LVL_W-1:0]   channel_level,
   input  wire logic [LVL_W-1:0]     bandgap_level,
   // processor side
   input  wire logic                 global_irq_enable,
   input  wire logic                 vector_ack,
   output logic                      comparator_irq_request,
   output logic                      irq,
   // analog control
   output logic                      comparator_powered,
   output logic                      neg_from_channel,
   // timer capture front end
   output logic                      capture_trigger,
   // digital pin buffers
   input  wire logic [1:0]           pin_digital_in,
   output logic [1:0]                pin_buffer_enable,
   output logic [1:0]                port_pin_value
);
   import cmpctl_pkg::*;

   logic [7:0]          cmp_ctl_r;
   logic [7:0]          conv_b_r;
   logic [7:0]          conv_chan_r;
   logic [1:0]          pin_buf_r;
   logic [IRQ_BITS-1:0] irq_stat_r;
   logic [IRQ_BITS-1:0] irq_stat_nxt;
   logic [IRQ_BITS-1:0] irq_mask_r;
   logic                flag_r;
   logic                flag_nxt;
   logic                sync1_r;
   logic                result_r;
   logic                prev_r;
   logic                capture_r;
   logic [1:0]          pin_val_r;

   function automatic logic [ADDR_W-3:0] reg_idx(input logic [7:0] i);
      reg_idx = (ADDR_W-2)'(i);
   endfunction

   function automatic logic [LVL_W-1:0] pick_chan(input logic [8*LVL_W-1:0] lv,
                                                  input logic [2:0] n);
      pick_chan = lv[n*LVL_W +: LVL_W];
   endfunction

   // bus decode
   wire                 access    = psel & penable;
   wire                 wr        = access & pwrite;
   wire                 rd        = access & ~pwrite;
   wire [ADDR_W-3:0]    idx       = paddr[ADDR_W-1:2];
   wire                 hit_ctl   = idx == reg_idx(IDX_CMP_CTL);
   wire                 hit_convb = idx == reg_idx(IDX_CONV_B);
   wire                 hit_chan  = idx == reg_idx(IDX_CONV_CHAN);
   wire                 hit_buf   = idx == reg_idx(IDX_PIN_BUF);
   wire                 hit_stat  = idx == reg_idx(IDX_IRQ_STAT);
   wire                 hit_mask  = idx == reg_idx(IDX_IRQ_MASK);
   wire                 mapped    = hit_ctl | hit_convb | hit_chan | hit_buf | hit_stat | hit_mask;

   // control fields
   wire                 cmp_off   = cmp_ctl_r[BIT_OFF];
   wire                 ref_sel   = cmp_ctl_r[BIT_REFSEL];
   wire                 irq_en    = cmp_ctl_r[BIT_IE];
   wire                 route_en  = cmp_ctl_r[BIT_ROUTE];
   wire [1:0]           mode      = cmp_ctl_r[BIT_MODE_HI:BIT_MODE_LO];
   wire                 mux_en    = conv_b_r[BIT_NEG_MUX];
   wire                 conv_en   = conv_chan_r[BIT_CONV_EN];
   wire [2:0]           chan_sel  = conv_chan_r[CHAN_HI:0];

   // input selection; the mux is used only while the converter enable bit is clear
   wire                 use_chan  = mux_en & ~conv_en;
   wire [LVL_W-1:0]     neg_level = use_chan ? pick_chan(channel_level, chan_sel)
                                             : negative_input_pin;
   wire [LVL_W-1:0]     pos_level = ref_sel ? bandgap_level : positive_input_pin;
   // an unpowered comparator reads low; toggling the off bit can therefore raise an edge
   wire                 raw_out   = ~cmp_off & (pos_level > neg_level);

   // edge detection on the synchronised result
   wire                 rise      = result_r & ~prev_r;
   wire                 fall      = ~result_r & prev_r;
   wire                 evt       = (mode == MODE_TOGGLE) ? (rise | fall)
                                  : (mode == MODE_FALL)   ? fall
                                  : (mode == MODE_RISE)   ? rise
                                  : 1'b0;

   // flag: hardware set beats either clear
   wire                 w1c_flag  = wr & hit_ctl & pwdata[BIT_FLAG];
   assign flag_nxt = evt | (flag_r & ~w1c_flag & ~vector_ack);

   // sticky status, cleared by reading it; a new event in that cycle survives
   wire [IRQ_BITS-1:0]  irq_src   = {rise | fall, evt};
   assign irq_stat_nxt = irq_src | (irq_stat_r & ~{IRQ_BITS{rd & hit_stat}});

   // read mux
   wire [7:0]           ctl_rd    = {cmp_ctl_r[7:6], result_r, flag_r, cmp_ctl_r[3:0]};
   wire [7:0]           convb_rd  = {1'b0, mux_en, 3'h0, conv_b_r[TRIG_HI:0]};
   wire [7:0]           buf_rd    = {6'h00, pin_buf_r};
   wire [7:0]           rd_byte   = hit_ctl   ? ctl_rd
                                  : hit_convb ? convb_rd
                                  : hit_chan  ? conv_chan_r
                                  : hit_buf   ? buf_rd
                                  : hit_stat  ? 8'(irq_stat_r)
                                  : hit_mask  ? 8'(irq_mask_r)
                                  : 8'h00;

   assign pready                 = 1'b1;
   assign pslverr                = access & ~mapped;
   assign prdata                 = {24'h000000, rd_byte};
   assign comparator_irq_request = flag_r & irq_en & global_irq_enable;
   assign irq                    = |(irq_stat_r & irq_mask_r);
   assign comparator_powered     = ~cmp_off;
   assign neg_from_channel       = use_chan;
   assign capture_trigger        = capture_r;
   assign pin_buffer_enable      = ~pin_buf_r;
   assign port_pin_value         = pin_val_r;

   // registers written by software
   always_ff @(posedge clk) begin
      if (rst) begin
         cmp_ctl_r   <= RST_CMP_CTL;
         conv_b_r    <= RST_CONV_B;
         conv_chan_r <= RST_CONV_CHAN;
         pin_buf_r   <= RST_PIN_BUF[1:0];
         irq_mask_r  <= RST_IRQ;
      end else if (wr) begin
         if (hit_ctl) begin
            cmp_ctl_r <= {pwdata[7:6], 2'h0, pwdata[3:0]};
         end
         if (hit_convb) begin
            conv_b_r <= {1'b0, pwdata[BIT_NEG_MUX], 3'h0, pwdata[TRIG_HI:0]};
         end
         if (hit_chan) begin
            conv_chan_r <= pwdata[7:0];
         end
         if (hit_buf) begin
            pin_buf_r <= pwdata[1:0];
         end
         if (hit_mask) begin
            irq_mask_r <= pwdata[IRQ_BITS-1:0];
         end
      end
   end

   // synchroniser; the first stage feeds only the second
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_r  <= 1'b0;
         result_r <= 1'b0;
         prev_r   <= 1'b0;
      end else begin
         sync1_r  <= raw_out;
         result_r <= sync1_r;
         prev_r   <= result_r;
      end
   end

   // flag, status, capture and pin outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         flag_r     <= 1'b0;
         irq_stat_r <= RST_IRQ;
         capture_r  <= 1'b0;
         pin_val_r  <= 2'h0;
      end else begin
         flag_r     <= flag_nxt;
         irq_stat_r <= irq_stat_nxt;
         capture_r  <= route_en & result_r;
         pin_val_r  <= pin_digital_in & ~pin_buf_r;
      end
   end

   sync_lat_a: assert property (@(posedge clk) disable iff (rst)
      ##2 (result_r == $past(raw_out, 2)))
      else $error("result not two stages behind comparator");

   flag_set_a: assert property (@(posedge clk) disable iff (rst)
      (mode == MODE_RISE && result_r && !prev_r) |=> flag_r)
      else $error("rising edge did not set flag");

   mode_rsvd_a: assert property (@(posedge clk) disable iff (rst)
      (mode == MODE_RSVD && !flag_r) |=> !flag_r)
      else $error("reserved mode raised flag");

   flag_vec_a: assert property (@(posedge clk) disable iff (rst)
      (vector_ack && !evt) |=> !flag_r)
      else $error("vector did not clear flag");

   flag_w1c_a: assert property (@(posedge clk) disable iff (rst)
      (wr && hit_ctl && !pwdata[BIT_FLAG] && !vector_ack && flag_r) |=> flag_r)
      else $error("write of zero cleared flag");

   irq_req_a: assert property (@(posedge clk) disable iff (rst)
      comparator_irq_request |-> (flag_r && irq_en && global_irq_enable))
      else $error("request without enable or global bit");

   cap_off_a: assert property (@(posedge clk) disable iff (rst)
      (!route_en ##1 !$past(route_en)) |-> !capture_trigger)
      else $error("capture path driven while unrouted");

   cap_on_a: assert property (@(posedge clk) disable iff (rst)
      (route_en && result_r) |=> capture_trigger)
      else $error("routed result did not reach capture");

   pin_mask_a: assert property (@(posedge clk) disable iff (rst)
      $past(pin_buf_r[0]) |-> !port_pin_value[0])
      else $error("disabled pin read nonzero");

   buf_rsvd_a: assert property (@(posedge clk) disable iff (rst)
      (rd && hit_buf) |-> (prdata[31:2] == 30'h0))
      else $error("buffer register upper bits nonzero");

   mux_sel_a: assert property (@(posedge clk) disable iff (rst)
      (!mux_en || conv_en) |-> (neg_level == negative_input_pin))
      else $error("channel used while mux disabled");

   off_low_a: assert property (@(posedge clk) disable iff (rst)
      cmp_off [*3] |-> !result_r)
      else $error("result high while powered off");

   // input muxes, edge kinds and bus answers
   chan_sel_a: assert property (@(posedge clk) disable iff (rst)
      use_chan |-> (neg_level == pick_chan(channel_level, chan_sel)))
      else $error("selected channel not applied");

   ref_pos_a: assert property (@(posedge clk) disable iff (rst)
      ref_sel |-> (pos_level == bandgap_level))
      else $error("bandgap not applied to positive input");

   pin_pos_a: assert property (@(posedge clk) disable iff (rst)
      !ref_sel |-> (pos_level == positive_input_pin))
      else $error("positive pin not applied");

   cmp_high_a: assert property (@(posedge clk) disable iff (rst)
      (!cmp_off && (pos_level > neg_level)) |=> sync1_r)
      else $error("comparator low although positive higher");

   cmp_low_a: assert property (@(posedge clk) disable iff (rst)
      !(pos_level > neg_level) |=> !sync1_r)
      else $error("comparator high although positive not higher");

   pwr_off_a: assert property (@(posedge clk) disable iff (rst)
      cmp_off |-> !comparator_powered)
      else $error("comparator powered while off bit set");

   flag_fall_a: assert property (@(posedge clk) disable iff (rst)
      (mode == MODE_FALL && !result_r && prev_r) |=> flag_r)
      else $error("falling edge did not set flag");

   flag_tog_a: assert property (@(posedge clk) disable iff (rst)
      (mode == MODE_TOGGLE && (result_r != prev_r)) |=> flag_r)
      else $error("toggle did not set flag");

   flag_hold_a: assert property (@(posedge clk) disable iff (rst)
      (flag_r && !vector_ack && !(wr && hit_ctl)) |=> flag_r)
      else $error("flag lost without a clear");

   flag_clr_a: assert property (@(posedge clk) disable iff (rst)
      (wr && hit_ctl && pwdata[BIT_FLAG] && !evt) |=> !flag_r)
      else $error("write of one did not clear flag");

   rise_only_a: assert property (@(posedge clk) disable iff (rst)
      (mode == MODE_RISE && !flag_r && !(result_r && !prev_r)) |=> !flag_r)
      else $error("rising mode flagged another edge");

   fall_only_a: assert property (@(posedge clk) disable iff (rst)
      (mode == MODE_FALL && !flag_r && !(!result_r && prev_r)) |=> !flag_r)
      else $error("falling mode flagged another edge");

   req_on_a: assert property (@(posedge clk) disable iff (rst)
      (flag_r && irq_en && global_irq_enable) |-> comparator_irq_request)
      else $error("request missing while enabled");

   ie_off_a: assert property (@(posedge clk) disable iff (rst)
      !irq_en |-> !comparator_irq_request)
      else $error("request while enable clear");

   cap_follow_a: assert property (@(posedge clk) disable iff (rst)
      route_en |=> (capture_trigger == $past(result_r)))
      else $error("capture input does not follow result");

   buf_en_a: assert property (@(posedge clk) disable iff (rst)
      pin_buf_r[1] |-> !pin_buffer_enable[1])
      else $error("negative pin buffer left on");

   pin_neg_a: assert property (@(posedge clk) disable iff (rst)
      pin_buf_r[1] |=> !port_pin_value[1])
      else $error("disabled negative pin read nonzero");

   flag_quiet_a: assert property (@(posedge clk) disable iff (rst)
      ((result_r == prev_r) && !flag_r) |=> !flag_r)
      else $error("flag set without a result change");

   err_unmap_a: assert property (@(posedge clk) disable iff (rst)
      (access && !mapped) |-> (pslverr && (prdata == 32'h0)))
      else $error("unmapped access not refused");

   err_map_a: assert property (@(posedge clk) disable iff (rst)
      (access && mapped) |-> !pslverr)
      else $error("mapped access refused");
endmodule
`default_nettype wire

// file: cmpctl_analog_model.sv
`timescale 1ns/100ps
`default_nettype none
module cmpctl_analog_model #(
   parameter int               LVL_W  = 10,
   parameter logic [LVL_W-1:0] BG_LVL = 10'h200
) (
   // system clock
   input  wire logic             clk,
   // levels into the comparator
   output logic [LVL_W-1:0]      pos_lvl,
   output logic [LVL_W-1:0]      neg_lvl,
   output logic [8*LVL_W-1:0]    chan_lvl,
   output logic [LVL_W-1:0]      bg_lvl,
   // timer capture front end
   input  wire logic             capture_trigger,
   output int                    captures
);
   logic cap_q;
   // bandgap held steady; its settling time is not modelled
   assign bg_lvl = BG_LVL;
   initial begin
      pos_lvl = '0;
      neg_lvl = '0;
      chan_lvl = '0;
      captures = 0;
      cap_q = 1'b0;
   end
   // capture front end counts rising edges of the routed result
   always @(posedge clk) begin
      cap_q <= capture_trigger;
      if (capture_trigger === 1'b1 && cap_q !== 1'b1)
         captures <= captures + 1;
   end
   task automatic set_lv(input logic [LVL_W-1:0] p, n, input logic [8*LVL_W-1:0] c);
      @(posedge clk);
      pos_lvl <= p;
      neg_lvl <= n;
      chan_lvl <= c;
   endtask
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import cmpctl_pkg::*;
   localparam int LW = 10;
   logic              clk, rst, psel, penable, pwrite, gie, vack;
   logic              pready, pslverr, req, irq, pwr, nfc, cap, er;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata, rd;
   logic [LW-1:0]     pos, neg, bg;
   logic [8*LW-1:0]   chl;
   logic [1:0]        pin_in, pbe, ppv;
   int                mismatches, compares, captures;
   cmpctl_top #(.LVL_W(LW)) dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .positive_input_pin(pos), .negative_input_pin(neg), .channel_level(chl), .bandgap_level(bg),
      .global_irq_enable(gie), .vector_ack(vack), .comparator_irq_request(req), .irq(irq),
      .comparator_powered(pwr), .neg_from_channel(nfc), .capture_trigger(cap),
      .pin_digital_in(pin_in), .pin_buffer_enable(pbe), .port_pin_value(ppv));
   cmpctl_analog_model #(.LVL_W(LW)) ana (.clk(clk), .pos_lvl(pos), .neg_lvl(neg), .chan_lvl(chl),
      .bg_lvl(bg), .capture_trigger(cap), .captures(captures));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic results;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   // one access; data taken at the edge where pready is seen, outputs settled on return
   task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= {24'h0, wd};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge clk);
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
      apb(1'b1, idx, wd);
   endtask
   task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 8'h00);
      check(nm, rd, exp);
   endtask
   task automatic rbit(input string nm, input logic [7:0] idx, input int b, input logic exp);
      apb(1'b0, idx, 8'h00);
      check(nm, 32'(rd[b]), 32'(exp));
   endtask
   task automatic lv(input logic [LW-1:0] p, n, input logic [8*LW-1:0] c);
      ana.set_lv(p, n, c);
      repeat (4) @(posedge clk);
   endtask
   task automatic t_reset;
      rdc("ctl", IDX_CMP_CTL, 32'(RST_CMP_CTL));
      rdc("convb", IDX_CONV_B, 32'(RST_CONV_B));
      rdc("chan", IDX_CONV_CHAN, 32'(RST_CONV_CHAN));
      check("powered", 32'(pwr), 32'h1);
      check("bufen", 32'(pbe), 32'h3);
      wr(IDX_PIN_BUF, 8'hFF);
      rdc("pinbuf", IDX_PIN_BUF, 32'h3);
      wr(IDX_CONV_B, 8'hFF);
      rdc("convb_ro", IDX_CONV_B, 32'h47);
      wr(IDX_CONV_B, 8'h00);
      wr(IDX_PIN_BUF, 8'h00);
      apb(1'b0, 8'h10, 8'h00);
      check("unmapped_err", 32'(er), 32'h1);
      check("unmapped_data", rd, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_mux;
      wr(IDX_CONV_B, 8'h40); // converter enable left clear while mux is used
      for (int c = 0; c < 8; c++) begin
         wr(IDX_CONV_CHAN, 8'(c));
         lv(10'd500, 10'd0, {{(7*LW){1'b0}}, {LW{1'b1}}} << (c * LW));
         check("mux_sel", 32'(nfc), 32'h1);
         rbit("mux_res", IDX_CMP_CTL, BIT_RESULT, 1'b0);
         wr(IDX_CONV_CHAN, 8'h80 | 8'(c));
         check("pin_sel", 32'(nfc), 32'h0);
         repeat (3) @(posedge clk);
         rbit("pin_res", IDX_CMP_CTL, BIT_RESULT, 1'b1);
      end
      wr(IDX_CONV_B, 8'h00);
      wr(IDX_CONV_CHAN, 8'h00);
      check("mux_off", 32'(nfc), 32'h0);
      $display("test mux done");
   endtask
   task automatic t_modes;
      logic [1:0] md [4];
      md = '{MODE_TOGGLE, MODE_FALL, MODE_RISE, MODE_RSVD};
      lv(10'd0, 10'd500, '0);
      foreach (md[i]) begin
         wr(IDX_CMP_CTL, 8'h10 | 8'(md[i])); // mode changed with enable clear
         lv(10'd600, 10'd500, '0);
         rbit("rise_flag", IDX_CMP_CTL, BIT_FLAG, md[i] == MODE_TOGGLE || md[i] == MODE_RISE);
         wr(IDX_CMP_CTL, 8'h10 | 8'(md[i]));
         rbit("w1c_flag", IDX_CMP_CTL, BIT_FLAG, 1'b0);
         lv(10'd0, 10'd500, '0);
         rbit("fall_flag", IDX_CMP_CTL, BIT_FLAG, md[i] == MODE_TOGGLE || md[i] == MODE_FALL);
      end
      $display("test modes done");
   endtask
   task automatic t_irq;
      wr(IDX_CMP_CTL, 8'h10);
      apb(1'b0, IDX_IRQ_STAT, 8'h00);
      wr(IDX_CMP_CTL, 8'h08);
      lv(10'd600, 10'd500, '0);
      check("req_gie_off", 32'(req), 32'h0);
      gie <= 1'b1;
      @(negedge clk);
      check("req_on", 32'(req), 32'h1);
      wr(IDX_CMP_CTL, 8'h08);
      rbit("w0_keeps", IDX_CMP_CTL, BIT_FLAG, 1'b1);
      @(posedge clk);
      vack <= 1'b1;
      @(posedge clk);
      vack <= 1'b0;
      @(negedge clk);
      check("req_vec", 32'(req), 32'h0);
      rbit("vec_clr", IDX_CMP_CTL, BIT_FLAG, 1'b0);
      wr(IDX_CMP_CTL, 8'h00);
      lv(10'd0, 10'd500, '0);
      check("req_ie_off", 32'(req), 32'h0);
      check("irq_masked", 32'(irq), 32'h0);
      wr(IDX_IRQ_MASK, 8'h01);
      check("irq_on", 32'(irq), 32'h1);
      rdc("stat", IDX_IRQ_STAT, 32'h3);
      check("irq_rdclr", 32'(irq), 32'h0);
      rdc("stat_clr", IDX_IRQ_STAT, 32'h0);
      @(posedge clk);
      gie <= 1'b0;
      $display("test irq done");
   endtask
   task automatic t_analog;
      int n0;
      wr(IDX_CMP_CTL, 8'h40);
      lv(10'd0, 10'h100, '0);
      rbit("bg_hi", IDX_CMP_CTL, BIT_RESULT, 1'b1);
      lv(10'h3FF, 10'h300, '0);
      rbit("bg_lo", IDX_CMP_CTL, BIT_RESULT, 1'b0);
      wr(IDX_CMP_CTL, 8'h80);
      check("off_pwr", 32'(pwr), 32'h0);
      repeat (3) @(posedge clk);
      rbit("off_res", IDX_CMP_CTL, BIT_RESULT, 1'b0);
      n0 = captures;
      wr(IDX_CMP_CTL, 8'h04);
      repeat (5) @(posedge clk);
      check("cap_on", 32'(cap), 32'h1);
      check("cap_cnt", 32'(captures), 32'(n0 + 1));
      lv(10'd0, 10'h300, '0);
      wr(IDX_CMP_CTL, 8'h00);
      lv(10'h3FF, 10'h300, '0);
      check("cap_off", 32'(cap), 32'h0);
      check("cap_cnt_off", 32'(captures), 32'(n0 + 1));
      $display("test analog done");
   endtask
   task automatic t_pins;
      pin_in <= 2'h3;
      wr(IDX_PIN_BUF, 8'h01);
      check("bufen_p", 32'(pbe), 32'h2);
      @(negedge clk);
      check("pin_p", 32'(ppv), 32'h2);
      wr(IDX_PIN_BUF, 8'h02);
      check("bufen_n", 32'(pbe), 32'h1);
      @(negedge clk);
      check("pin_n", 32'(ppv), 32'h1);
      $display("test pins done");
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      results;
   end
   initial begin
      mismatches = 0;
      compares = 0;
      rst = 1'b1;
      {psel, penable, pwrite, gie, vack} = '0;
      paddr = '0;
      pwdata = '0;
      pin_in = '0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_mux;
      t_modes;
      t_irq;
      t_analog;
      t_pins;
      results;
   end
endmodule
`default_nettype wire
